// file: verilog/csg_map.vh
// Address map, field positions, reset values and timing counts of the
// clock manager startup gating block.
// Assumes a 32-bit APB bus with byte addresses and one aligned word per register.
`ifndef CSG_MAP_VH
`define CSG_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define CSG_OFF_CTRL        12'h000
`define CSG_OFF_WAIT_MASK   12'h004
`define CSG_OFF_STATUS      12'h008
`define CSG_OFF_IRQ_STAT    12'h00c
`define CSG_OFF_IRQ_MASK    12'h010
`define CSG_OFF_FREQ        12'h014

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define CSG_CTRL_LOCK_PHASE 0
`define CSG_CTRL_ALIGN_MODE 1
`define CSG_CTRL_HALVING    2
`define CSG_CTRL_CASCADED   3
`define CSG_CTRL_EXT_FB     4
`define CSG_CTRL_SRC_GLOBAL 5
`define CSG_CTRL_W          6
`define CSG_CTRL_RESET      6'h20

// Status register fields
`define CSG_ST_DONE         0
`define CSG_ST_HOLD_OK      1
`define CSG_ST_FREQ_HIGH    2
`define CSG_ST_ALIGN_EFF    3
`define CSG_ST_CM_LOCK      8
`define CSG_ST_PLL_LOCK     16

// Interrupt fields
`define CSG_IRQ_DONE        0
`define CSG_IRQ_LOCK_LOST   1
`define CSG_IRQ_W           2
`define CSG_IRQ_RESET       2'h0

////////////////////////////////////////////////////////////////////////////////
// Timing
// Measurement window of 10 us at the 100 MHz clk
`define CSG_MEAS_CYCLES     16'h03e8
`define CSG_FREQ_HIGH_EDGES 16'h00c8
`define CSG_RST_REF_EDGES   2'h3

`endif

// file: verilog/csg_sync.v
// Three-stage synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps

module csg_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         nrst,
  // Asynchronous levels in, filtered levels out
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  ////////////////////////////////////////////////////////////////////////////////
  // Stage one feeds stage two only; a bit changes once stages two and three agree
  always @(posedge clk) begin
    if (!nrst) begin
      s1   <= {W{1'b0}};
      s2   <= {W{1'b0}};
      s3   <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= (s2 & s3) | (~(s2 ^ s3) & s2) | ((s2 ^ s3) & dout);
    end
  end

endmodule

// file: verilog/csg_startup_gate.v
// Startup gating and input conditioning for a group of clock managers.
// Assumes: APB master on clk, lock and reference inputs asynchronous,
// reference clock well below a quarter of clk since it is sampled.
// Lock, reference and end-of-configuration pins are treated as slow levels;
// a pulse shorter than two clk periods may be missed by the filter.
//
// Function
// - With wait-for-lock set, configuration-done stays low until that manager locks.
// - Wait-for-lock off by default; done then follows end of configuration alone.
// - Lock indicators pass through untouched; waiting never holds them back.
// - Several waiting managers: startup holds until every one of them locked.
// - Lock-wait phase without any wait bit: wait for all managers and PLLs.
// - Halving on: reference divided by two, near fifty percent duty.
// - Halving off by default: reference goes straight to the manager.
// - Frequency mode and measurement use the halved rate when halving is on.
// - Alignment mode picks system-synchronous default or source-synchronous delay.
// - Alignment mode ignored when cascaded, external feedback, or non-global source.
// - Lock high means valid; a falling lock is lost lock and forces manager reset.
// - Options load during configuration and freeze once done is reached.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "csg_map.vh"

module csg_startup_gate #(
  parameter N_CM  = 4,
  parameter N_PLL = 2
) (
  // Clock and reset
  input  wire              clk,
  input  wire              nrst,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  // Interrupt
  output wire              irq,
  // Startup sequencer side
  input  wire              config_end,
  output reg               config_done,
  output wire              lock_wait_startup_phase,
  // Clock manager side
  input  wire              reference_clock_in,
  input  wire [N_CM-1:0]   cm_lock_in,
  input  wire [N_PLL-1:0]  pll_lock_in,
  output reg               cm_clk_in,
  output reg  [N_CM-1:0]   cm_lock_out,
  output reg  [N_CM-1:0]   cm_reset,
  output reg               input_delay_alignment_mode
);

  // Synchroniser width covers locks, reference and end of configuration
  localparam SW = N_CM + N_PLL + 2;
  localparam [15:0] MEAS_CYCLES = `CSG_MEAS_CYCLES;

  ////////////////////////////////////////////////////////////////////////////////
  // All requested locks present; bits outside the need mask do not matter
  // Widening to 32 bits lets one function serve managers and PLLs alike
  function locks_met;
    input [31:0] locks;
    input [31:0] need;
    begin
      locks_met = &(locks | ~need);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs
  wire [SW-1:0]    sync_out;
  wire [N_CM-1:0]  cm_lock;
  wire [N_PLL-1:0] pll_lock;
  wire             ref_s;
  wire             cfg_end_s;

  csg_sync #(
    .W (SW)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({config_end, reference_clock_in, pll_lock_in, cm_lock_in}),
    .dout (sync_out)
  );

  assign cm_lock   = sync_out[N_CM-1:0];
  assign pll_lock  = sync_out[N_CM+N_PLL-1:N_CM];
  assign ref_s     = sync_out[N_CM+N_PLL];
  assign cfg_end_s = sync_out[N_CM+N_PLL+1];

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [`CSG_CTRL_W-1:0] ctrl;
  reg  [N_CM-1:0]        wait_mask;
  reg  [`CSG_IRQ_W-1:0]  irq_stat;
  reg  [`CSG_IRQ_W-1:0]  irq_mask;
  reg  [15:0]            freq_count;
  reg                    freq_high;
  reg                    hold_ok;

  wire opt_lock_phase = ctrl[`CSG_CTRL_LOCK_PHASE];
  wire opt_align      = ctrl[`CSG_CTRL_ALIGN_MODE];
  wire opt_halving    = ctrl[`CSG_CTRL_HALVING];
  wire opt_cascaded   = ctrl[`CSG_CTRL_CASCADED];
  wire opt_ext_fb     = ctrl[`CSG_CTRL_EXT_FB];
  wire opt_src_global = ctrl[`CSG_CTRL_SRC_GLOBAL];

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states
  // pready is tied high, so every access completes in its first access cycle
  // Unmapped offsets answer with pslverr rather than stalling the bus
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire hit_ctrl = (paddr == `CSG_OFF_CTRL);
  wire hit_wait = (paddr == `CSG_OFF_WAIT_MASK);
  wire hit_st   = (paddr == `CSG_OFF_STATUS);
  wire hit_is   = (paddr == `CSG_OFF_IRQ_STAT);
  wire hit_im   = (paddr == `CSG_OFF_IRQ_MASK);
  wire hit_fq   = (paddr == `CSG_OFF_FREQ);
  wire mapped   = hit_ctrl | hit_wait | hit_st | hit_is | hit_im | hit_fq;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Options are configuration data: frozen once done is reached
  // Later writes to them are dropped silently, without an error response,
  // since software has no business changing them at run time
  wire opt_wr_ok = ~config_done;

  always @(posedge clk) begin
    if (!nrst) begin
      ctrl      <= `CSG_CTRL_RESET;
      wait_mask <= {N_CM{1'b0}};
      irq_mask  <= `CSG_IRQ_RESET;
    end else if (wr) begin
      if (hit_ctrl && opt_wr_ok) begin
        ctrl <= pwdata[`CSG_CTRL_W-1:0];
      end else if (hit_wait && opt_wr_ok) begin
        wait_mask <= pwdata[N_CM-1:0];
      end else if (hit_im) begin
        irq_mask <= pwdata[`CSG_IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped and reserved bits read as zero
  // prdata loads in the setup cycle so it stands for the whole access phase
  wire [31:0] status_word;
  assign status_word = ({{(32-N_CM){1'b0}}, cm_lock} << `CSG_ST_CM_LOCK)
                     | ({{(32-N_PLL){1'b0}}, pll_lock} << `CSG_ST_PLL_LOCK)
                     | ({31'h0, input_delay_alignment_mode} << `CSG_ST_ALIGN_EFF)
                     | ({31'h0, freq_high} << `CSG_ST_FREQ_HIGH)
                     | ({31'h0, hold_ok} << `CSG_ST_HOLD_OK)
                     | ({31'h0, config_done} << `CSG_ST_DONE);

  always @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {{(32-`CSG_CTRL_W){1'b0}}, ctrl};
      end else if (hit_wait) begin
        prdata <= {{(32-N_CM){1'b0}}, wait_mask};
      end else if (hit_st) begin
        prdata <= status_word;
      end else if (hit_is) begin
        prdata <= {{(32-`CSG_IRQ_W){1'b0}}, irq_stat};
      end else if (hit_im) begin
        prdata <= {{(32-`CSG_IRQ_W){1'b0}}, irq_mask};
      end else if (hit_fq) begin
        prdata <= {16'h0, freq_count};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Startup hold condition
  // The sequencer must itself drop global tristate first, otherwise no lock ever comes
  // With no wait bit and no lock phase the hold condition is always met
  wire any_wait = |wait_mask;
  wire gate_on  = opt_lock_phase | any_wait;
  wire waited_ok = locks_met({{(32-N_CM){1'b0}}, cm_lock},
                             {{(32-N_CM){1'b0}}, wait_mask});
  wire all_ok    = locks_met({{(32-N_CM){1'b0}}, cm_lock}, {{(32-N_CM){1'b0}}, {N_CM{1'b1}}})
                 & locks_met({{(32-N_PLL){1'b0}}, pll_lock}, {{(32-N_PLL){1'b0}}, {N_PLL{1'b1}}});
  wire next_hold_ok = ~gate_on | (any_wait ? waited_ok : all_ok);

  assign lock_wait_startup_phase = opt_lock_phase;

  // Done is sticky: a later loss of lock does not revoke configuration
  // The done interrupt comes from the same one-cycle pulse, so it cannot be missed
  wire done_rise = ~config_done & cfg_end_s & next_hold_ok;

  always @(posedge clk) begin
    if (!nrst) begin
      hold_ok     <= 1'b0;
      config_done <= 1'b0;
    end else begin
      hold_ok <= next_hold_ok;
      if (done_rise) begin
        config_done <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lock pass-through and lost-lock detection
  // The pass-through adds one register after the filter and nothing else,
  // so a waiting configuration never delays a manager's lock
  reg  [N_CM-1:0] lock_prev;
  wire [N_CM-1:0] lock_fall = lock_prev & ~cm_lock;
  wire            lost_any  = |lock_fall;

  always @(posedge clk) begin
    if (!nrst) begin
      lock_prev   <= {N_CM{1'b0}};
      cm_lock_out <= {N_CM{1'b0}};
    end else begin
      lock_prev   <= cm_lock;
      cm_lock_out <= cm_lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference edge detect and halving toggle
  // Sampling limits the reference to well below a quarter of clk; faster inputs
  // alias, and the halved clock then loses its even duty
  reg  ref_prev;
  reg  half_tog;
  wire ref_rise = ref_s & ~ref_prev;

  always @(posedge clk) begin
    if (!nrst) begin
      ref_prev  <= 1'b0;
      half_tog  <= 1'b0;
      cm_clk_in <= 1'b0;
    end else begin
      ref_prev <= ref_s;
      if (ref_rise) begin
        half_tog <= ~half_tog;
      end
      // Toggle gives even duty regardless of the reference's own duty
      cm_clk_in <= opt_halving ? (half_tog ^ ref_rise) : ref_s;
    end
  end

  // Effective manager input edge, used for measurement and reset timing
  // With halving it is the edge on which the toggle goes from low to high
  wire eff_rise = opt_halving ? (ref_rise & ~half_tog) : ref_rise;

  ////////////////////////////////////////////////////////////////////////////////
  // Manager reset after lost lock, held for a few manager input edges
  // A fresh loss restarts the count, so the reset always spans full edges
  // All managers that lost lock share one count and are released together
  reg [1:0] rst_edges;

  always @(posedge clk) begin
    if (!nrst) begin
      cm_reset  <= {N_CM{1'b0}};
      rst_edges <= 2'h0;
    end else begin
      if (lost_any) begin
        cm_reset  <= cm_reset | lock_fall;
        rst_edges <= 2'h0;
      end else if (|cm_reset) begin
        if (eff_rise) begin
          if (rst_edges == `CSG_RST_REF_EDGES - 2'h1) begin
            cm_reset  <= {N_CM{1'b0}};
            rst_edges <= 2'h0;
          end else begin
            rst_edges <= rst_edges + 2'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frequency measurement over a fixed window of clk cycles
  // Counts effective edges, so the halved rate decides the mode
  // The window restarts on reset only; the first result after reset covers a whole window
  reg [15:0] win_cnt;
  reg [15:0] edge_cnt;

  always @(posedge clk) begin
    if (!nrst) begin
      win_cnt    <= 16'h0;
      edge_cnt   <= 16'h0;
      freq_count <= 16'h0;
      freq_high  <= 1'b0;
    end else if (win_cnt == MEAS_CYCLES - 16'h1) begin
      win_cnt    <= 16'h0;
      edge_cnt   <= 16'h0;
      freq_count <= edge_cnt + {15'h0, eff_rise};
      freq_high  <= (edge_cnt + {15'h0, eff_rise}) > `CSG_FREQ_HIGH_EDGES;
    end else begin
      win_cnt  <= win_cnt + 16'h1;
      edge_cnt <= edge_cnt + {15'h0, eff_rise};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Delay alignment mode, forced to system-synchronous where it cannot act
  // Only steers input delay; phase shifts belong to the phase settings
  // Held in a register so the mode output never glitches on option writes
  wire align_applies = ~opt_cascaded & ~opt_ext_fb & opt_src_global;

  always @(posedge clk) begin
    if (!nrst) begin
      input_delay_alignment_mode <= 1'b0;
    end else begin
      input_delay_alignment_mode <= opt_align & align_applies;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear; a new event wins over the clear
  wire [`CSG_IRQ_W-1:0] irq_ev  = {lost_any, done_rise};
  wire [`CSG_IRQ_W-1:0] irq_clr = (wr && hit_is) ? pwdata[`CSG_IRQ_W-1:0] : `CSG_IRQ_RESET;

  always @(posedge clk) begin
    if (!nrst) begin
      irq_stat <= `CSG_IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
    end
  end

  // Mask changes act at once since irq is a plain combination of state
  assign irq = |(irq_stat & irq_mask);

endmodule

// file: tb/csg_startup_gate_props.sv
// Checker for the startup gate: watches only the top module's ports.
// Assumes one clock domain and the four-edge input synchronisers.
`timescale 1ns/1ps
module csg_props #(
  parameter N_CM  = 4,
  parameter N_PLL = 2
) (
  // Clock and reset
  input wire            clk,
  input wire            nrst,
  // Register bus
  input wire            psel,
  input wire            penable,
  input wire            pwrite,
  input wire [11:0]     paddr,
  input wire [31:0]     pwdata,
  // Startup and manager side
  input wire            config_end,
  input wire            config_done,
  input wire            lock_wait_startup_phase,
  input wire            reference_clock_in,
  input wire [N_CM-1:0] cm_lock_in,
  input wire            cm_clk_in,
  input wire [N_CM-1:0] cm_lock_out,
  input wire [N_CM-1:0] cm_reset,
  input wire            input_delay_alignment_mode
);
  reg  [3:0]      up;
  reg  [5:0]      ctl;
  reg  [N_CM-1:0] wm;
  wire            wr = psel & penable & pwrite & ~config_done;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the option registers; up keeps $past away from reset values
  always @(posedge clk) begin
    if (!nrst) begin
      up  <= 4'h0;
      ctl <= 6'h20;
      wm  <= {N_CM{1'b0}};
    end else begin
      if (up != 4'h8) up <= up + 4'h1;
      if (wr && paddr == 12'h000) ctl <= pwdata[5:0];
      if (wr && paddr == 12'h004) wm <= pwdata[N_CM-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_done_after_end: assert property ($rose(config_done) |-> $past(config_end, 4))
    else $error("done rose without end of configuration");
  a_wait_all_locked: assert property ($rose(config_done) |-> (cm_lock_out & wm) == wm)
    else $error("done rose before waited managers locked");
  a_phase_all_locked: assert property ($rose(config_done) && lock_wait_startup_phase && wm == 0 |-> &cm_lock_out)
    else $error("done rose in lock phase before all managers locked");
  a_lock_passes: assert property (up == 4'h8 |-> cm_lock_out == $past(cm_lock_in, 5))
    else $error("lock indicator held back");
  a_loss_resets: assert property (up == 4'h8 && |(~cm_lock_out & $past(cm_lock_out)) |-> ##[0:1] |cm_reset)
    else $error("lost lock without manager reset");
  a_direct_ref: assert property (up == 4'h8 && !ctl[2] && !$past(ctl[2], 6)
    |-> cm_clk_in == $past(reference_clock_in, 5))
    else $error("reference not passed straight through");
  a_align_effect: assert property (ctl == $past(ctl)
    |-> input_delay_alignment_mode == (ctl[1] & ~ctl[3] & ~ctl[4] & ctl[5]))
    else $error("alignment mode effect wrong");
  a_done_sticky: assert property (config_done |=> config_done)
    else $error("done dropped");
endmodule
bind csg_startup_gate csg_props #(.N_CM(N_CM), .N_PLL(N_PLL)) u_props (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .config_end(config_end), .config_done(config_done),
  .lock_wait_startup_phase(lock_wait_startup_phase), .reference_clock_in(reference_clock_in),
  .cm_lock_in(cm_lock_in), .cm_clk_in(cm_clk_in), .cm_lock_out(cm_lock_out), .cm_reset(cm_reset),
  .input_delay_alignment_mode(input_delay_alignment_mode));

// file: tb/csg_far.sv
// Far-side model: startup sequencer and clock managers.
// Assumes the bench commands lock targets; the reference runs free.
`timescale 1ns/1ps
module csg_far (
  // Commands from the bench
  input  wire       tristate_rel,
  input  wire       end_req,
  input  wire [3:0] cm_want,
  input  wire [1:0] pll_want,
  // Lines toward the gate
  output reg        ref_clk,
  output reg        cfg_end,
  output reg  [3:0] cm_lock,
  output reg  [1:0] pll_lock
);
  initial ref_clk = 1'b0;
  initial cfg_end = 1'b0;
  initial cm_lock = 4'h0;
  initial pll_lock = 2'h0;
  // Half period is a multiple of 16 ps, so no reference edge meets a clk rising edge
  always #100.304 ref_clk = ~ref_clk;
  // Lock follows a reference edge later, never while tristate is held
  always @(posedge ref_clk) begin
    cm_lock  <= cm_want & {4{tristate_rel}};
    pll_lock <= pll_want & {2{tristate_rel}};
    cfg_end  <= end_req;
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the startup gate with the far-side model.
// Assumes the register map header is on the include path.
`timescale 1ns/1ps
`include "csg_map.vh"
module tb;
  reg         clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [11:0] paddr = 12'h0;
  reg  [31:0] pwdata = 32'h0, seed = 32'h0001590f;
  reg         tristate_rel = 1'b0, end_req = 1'b0;
  reg  [3:0]  cm_want = 4'h0;
  reg  [1:0]  pll_want = 2'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, cfg_end, done, lphase, ref_clk, cm_clk, align;
  wire [3:0]  lk_in, lk_out, cm_rst;
  wire [1:0]  pll_lk;
  reg  [64:0] q[$];
  reg  [64:0] note;
  integer     error_cnt = 0, n_checks = 0, tick = 0, i, n;
  reg  [5:0]  c;
  csg_startup_gate #(.N_CM(4), .N_PLL(2)) uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .config_end(cfg_end), .config_done(done), .lock_wait_startup_phase(lphase),
    .reference_clock_in(ref_clk), .cm_lock_in(lk_in), .pll_lock_in(pll_lk), .cm_clk_in(cm_clk),
    .cm_lock_out(lk_out), .cm_reset(cm_rst), .input_delay_alignment_mode(align));
  csg_far far (.tristate_rel(tristate_rel), .end_req(end_req), .cm_want(cm_want), .pll_want(pll_want),
    .ref_clk(ref_clk), .cfg_end(cfg_end), .cm_lock(lk_in), .pll_lock(pll_lk));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input [32:0] got, input [32:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge clk);
  endtask
  // One APB transfer, then an idle cycle so strobes never change twice at one edge
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] v, input e);
    begin
      q.push_back({e, m, v});
      apb(a, 1'b0, 32'h0);
    end
  endtask
  task rst(input integer settle);
    begin
      end_req <= 1'b0;
      cm_want <= 4'h0;
      pll_want <= 2'h0;
      cyc(settle);
      nrst <= 1'b0;
      cyc(8);
      nrst <= 1'b1;
      cyc(1);
    end
  endtask
  task count_rises(output integer k);
    integer j;
    reg     prev;
    begin
      k = 0;
      prev = cm_clk;
      for (j = 0; j < 2000; j = j + 1) begin
        @(posedge clk);
        if (cm_clk && !prev) k = k + 1;
        prev = cm_clk;
      end
    end
  endtask
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Monitor: each completed read takes the oldest note and compares masked data and error
  always @(posedge clk) begin
    tick <= tick + 1;
    if (psel && penable && pready && !pwrite && q.size() != 0) begin
      note = q.pop_front();
      chk({pslverr, prdata & note[63:32]}, {note[64], note[31:0] & note[63:32]});
    end
    // Timeout last, so nothing in this process follows the verdict
    if (tick == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst(0);
    tristate_rel <= 1'b1;
    rd(`CSG_OFF_CTRL, 32'h3f, `CSG_CTRL_RESET, 1'b0);
    rd(`CSG_OFF_WAIT_MASK, 32'hf, 32'h0, 1'b0);
    rd(12'h018, 32'hffffffff, 32'h0, 1'b1);
    for (i = 0; i < 16; i = i + 1) begin
      c = {i[3], i[2], i[1], 1'b0, i[0], 1'b0};
      // Alignment is tried over every mix of mode, cascade, feedback and source, never asked to shift phase
      apb(`CSG_OFF_CTRL, 1'b1, {26'h0, c});
      cyc(3);
      chk({32'h0, align}, {32'h0, c[1] & ~c[3] & ~c[4] & c[5]});
    end
    apb(`CSG_OFF_CTRL, 1'b1, 32'h20);
    count_rises(n);
    chk({32'h0, n >= 97 && n <= 101}, 33'h1);
    // About 50 edges per window at the direct rate; 48 to 51 read alike under the mask
    rd(`CSG_OFF_FREQ, 32'hfffc, 32'h30, 1'b0);
    end_req <= 1'b1;
    cyc(40);
    rd(`CSG_OFF_STATUS, 32'h1, 32'h1, 1'b0);
    rd(`CSG_OFF_IRQ_STAT, 32'h3, 32'h1, 1'b0);
    chk({32'h0, irq}, 33'h0);
    apb(`CSG_OFF_IRQ_MASK, 1'b1, 32'h1);
    chk({32'h0, irq}, 33'h1);
    apb(`CSG_OFF_IRQ_STAT, 1'b1, 32'h1);
    chk({32'h0, irq}, 33'h0);
    apb(`CSG_OFF_CTRL, 1'b1, 32'h1);
    rd(`CSG_OFF_CTRL, 32'h3f, 32'h20, 1'b0);
    // Random waited set always holds manager 0, which stays unlocked at first
    rst(30);
    seed = xs(seed);
    apb(`CSG_OFF_WAIT_MASK, 1'b1, {28'h0, seed[3:0] | 4'h1});
    apb(`CSG_OFF_CTRL, 1'b1, 32'h21);
    end_req <= 1'b1;
    cm_want <= 4'he;
    cyc(60);
    rd(`CSG_OFF_STATUS, 32'hf01, 32'he00, 1'b0);
    cm_want <= 4'hf;
    cyc(60);
    rd(`CSG_OFF_STATUS, 32'hf01, 32'hf01, 1'b0);
    // Lock phase, no wait bits, halving on; one PLL late
    rst(30);
    apb(`CSG_OFF_CTRL, 1'b1, 32'h25);
    chk({32'h0, lphase}, 33'h1);
    end_req <= 1'b1;
    cm_want <= 4'hf;
    pll_want <= 2'h1;
    count_rises(n);
    chk({32'h0, n >= 48 && n <= 51}, 33'h1);
    // Halved rate gives 24 or 25 edges per window
    rd(`CSG_OFF_FREQ, 32'hfffe, 32'h18, 1'b0);
    rd(`CSG_OFF_STATUS, 32'h1, 32'h0, 1'b0);
    pll_want <= 2'h3;
    cyc(60);
    rd(`CSG_OFF_STATUS, 32'h1, 32'h1, 1'b0);
    cm_want <= 4'h7;
    cyc(30);
    chk({32'h0, cm_rst[3]}, 33'h1);
    rd(`CSG_OFF_IRQ_STAT, 32'h2, 32'h2, 1'b0);
    cyc(200);
    chk({32'h0, cm_rst[3]}, 33'h0);
    rd(`CSG_OFF_STATUS, 32'h1, 32'h1, 1'b0);
    cyc(5);
    print_verdict;
  end
endmodule
